// File: core/pin_interrupt_detector.sv
// pin interrupt detector: two external interrupt inputs and eight port pin interrupts
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module pin_interrupt_detector
	import pin_irq_pkg::*;
(
	// clock, reset, enable
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       CE,
	// clock source strap
	input  wire logic [1:0] CLK_SOURCE,
	// pins
	input  wire logic       OSC_PIN_A,
	input  wire logic       OSC_PIN_B,
	input  wire logic [7:0] PORT_ONE_PIN,
	// core vectoring
	input  wire logic [1:0] EXT_SERVICE_ENTER,
	// register port
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	// requests to the core
	output logic      [1:0] EXT_IRQ_REQUEST,
	output logic            PORT_IRQ_REQUEST,
	output logic            IRQ
);
	logic [7:0]            polarity_reg;
	logic [7:0]            enable_reg;
	logic [7:0]            flags_reg;
	logic [7:0]            flags_next;
	logic [7:0]            mode_reg;
	logic [EXT_COUNT-1:0]  type_reg;
	logic [EXT_COUNT-1:0]  ext_flag_reg;
	logic [EXT_COUNT-1:0]  ext_flag_next;
	logic [STAT_WIDTH-1:0] stat_reg;
	logic [STAT_WIDTH-1:0] stat_next;
	logic [STAT_WIDTH-1:0] mask_reg;
	logic [7:0]            rdata_reg;
	logic [1:0]            clksrc_reg;
	logic                  strap_taken_reg;
	logic [7:0]            pin_detect;
	logic [EXT_COUNT-1:0]  ext_detect;
	logic [EXT_COUNT-1:0]  ext_avail;
	logic [EXT_COUNT-1:0]  ext_pin;
	logic [EXT_COUNT-1:0]  ext_level_req;
	logic [STAT_WIDTH-1:0] events;
	logic                  wr_pol;
	logic                  wr_en;
	logic                  wr_flags;
	logic                  wr_mode;
	logic                  wr_ext;
	logic                  wr_mask;
	logic                  rd_stat;
	logic [7:0]            ext_ctrl_view;
	logic [7:0]            rd_mux;

	// strap caught after reset release, never under reset
	always_ff @(posedge CLK)
	begin
		if (RESET)
			strap_taken_reg <= 1'b0;
		else if (CE && !strap_taken_reg)
			strap_taken_reg <= 1'b1;
	end

	// capture waits for the first enabled edge, so a frozen block keeps its strap
	always_ff @(posedge CLK)
	begin
		if (RESET)
			clksrc_reg <= CLKSRC_CRYSTAL;
		else if (CE && !strap_taken_reg)
			clksrc_reg <= CLK_SOURCE;
	end

	// pins shared with the oscillator only serve when no crystal uses them
	assign ext_avail[0] = (clksrc_reg == CLKSRC_RC);
	assign ext_avail[1] = (clksrc_reg == CLKSRC_RC) | (clksrc_reg == CLKSRC_EXTERN);
	assign ext_pin      = {OSC_PIN_B, OSC_PIN_A};

	// port lanes: mode bit 0 level, 1 edge; two-sample level qualification
	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1)
		begin : port_lane
			pin_sense u_sense (
				.CLK         (CLK),
				.RESET       (RESET),
				.CE          (CE),
				.PIN         (PORT_ONE_PIN[g]),
				.EDGE_MODE   (mode_reg[g]),
				.ACTIVE_HIGH (polarity_reg[g]),
				.LEVEL_TWICE (1'b1),
				.DETECT      (pin_detect[g])
			);
		end
		// ext lanes: active low always, falling edge when type set
		for (g = 0; g < EXT_COUNT; g = g + 1)
		begin : ext_lane
			pin_sense u_sense (
				.CLK         (CLK),
				.RESET       (RESET),
				.CE          (CE),
				.PIN         (ext_pin[g]),
				.EDGE_MODE   (type_reg[g]),
				.ACTIVE_HIGH (1'b0),
				.LEVEL_TWICE (1'b0),
				.DETECT      (ext_detect[g])
			);
		end
	endgenerate

	// register decode
	assign wr_pol   = WR & (ADDR == ADDR_POLARITY);
	assign wr_en    = WR & (ADDR == ADDR_ENABLE);
	assign wr_flags = WR & (ADDR == ADDR_FLAGS);
	assign wr_mode  = WR & (ADDR == ADDR_MODE);
	assign wr_ext   = WR & (ADDR == ADDR_EXT_CTRL);
	assign wr_mask  = WR & (ADDR == ADDR_IRQ_MASK);
	assign rd_stat  = RD & (ADDR == ADDR_IRQ_STAT);

	// flags: software write stores, new detection wins over a clear
	assign flags_next = (wr_flags ? WDATA : flags_reg) | (pin_detect & enable_reg);

	// level mode: request follows the pin, no flag latching
	assign ext_level_req = ext_detect & ~type_reg & ext_avail;

	always_comb
	begin
		ext_flag_next = ext_flag_reg;
		if (wr_ext)
		begin
			ext_flag_next[0] = WDATA[BIT_FLAG0];
			ext_flag_next[1] = WDATA[BIT_FLAG1];
		end
		// vectoring clears edge flags; a coincident edge still sets
		ext_flag_next = ext_flag_next & ~(EXT_SERVICE_ENTER & type_reg);
		ext_flag_next = ext_flag_next | (ext_detect & type_reg & ext_avail);
		ext_flag_next = ext_flag_next & type_reg;
	end

	assign events = {|(pin_detect & enable_reg), ext_flag_next[1] & ~ext_flag_reg[1],
		ext_flag_next[0] & ~ext_flag_reg[0]};
	// read of status clears it; an event in the same cycle survives
	assign stat_next = (rd_stat ? {STAT_WIDTH{1'b0}} : stat_reg) | events;

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			polarity_reg <= REG_RESET;
			enable_reg   <= REG_RESET;
			flags_reg    <= REG_RESET;
			mode_reg     <= REG_RESET;
			type_reg     <= '0;
			ext_flag_reg <= '0;
			stat_reg     <= '0;
			mask_reg     <= '0;
		end
		else if (CE)
		begin
			if (wr_pol)
				polarity_reg <= WDATA;
			if (wr_en)
				enable_reg <= WDATA;
			if (wr_mode)
				mode_reg <= WDATA;
			if (wr_ext)
				type_reg <= {WDATA[BIT_TYPE1], WDATA[BIT_TYPE0]};
			if (wr_mask)
				mask_reg <= WDATA[STAT_WIDTH-1:0];
			flags_reg    <= flags_next;
			ext_flag_reg <= ext_flag_next;
			stat_reg     <= stat_next;
		end
	end

	// read side
	assign ext_ctrl_view = {4'h0, ext_flag_reg[1], ext_flag_reg[0], type_reg[1], type_reg[0]};

	always_comb
	begin
		case (ADDR)
			ADDR_POLARITY: rd_mux = polarity_reg;
			ADDR_ENABLE:   rd_mux = enable_reg;
			ADDR_FLAGS:    rd_mux = flags_reg;
			ADDR_MODE:     rd_mux = mode_reg;
			ADDR_EXT_CTRL: rd_mux = ext_ctrl_view;
			ADDR_IRQ_STAT: rd_mux = {5'h00, stat_reg};
			ADDR_IRQ_MASK: rd_mux = {5'h00, mask_reg};
			default:       rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			rdata_reg <= 8'h00;
		else if (CE)
			rdata_reg <= RD ? rd_mux : 8'h00;
	end

	assign RDATA            = rdata_reg;
	assign EXT_IRQ_REQUEST  = ext_flag_reg | ext_level_req;
	assign PORT_IRQ_REQUEST = |flags_reg;
	assign IRQ              = |(stat_reg & mask_reg);
endmodule

// File: core/pin_irq_pkg.sv
// package: register map, field positions and reset values for the pin interrupt detector
package pin_irq_pkg;
	localparam logic [7:0] ADDR_POLARITY  = 8'h9b;
	localparam logic [7:0] ADDR_ENABLE    = 8'h9c;
	localparam logic [7:0] ADDR_FLAGS     = 8'h9d;
	localparam logic [7:0] ADDR_MODE      = 8'h9e;
	localparam logic [7:0] ADDR_EXT_CTRL  = 8'h9f;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'ha0;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'ha1;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam int         PIN_COUNT      = 8;
	localparam int         EXT_COUNT      = 2;
	// ext control fields
	localparam int         BIT_TYPE0      = 0;
	localparam int         BIT_TYPE1      = 1;
	localparam int         BIT_FLAG0      = 2;
	localparam int         BIT_FLAG1      = 3;
	// irq status fields
	localparam int         BIT_ST_EXT0    = 0;
	localparam int         BIT_ST_EXT1    = 1;
	localparam int         BIT_ST_PIN     = 2;
	localparam int         STAT_WIDTH     = 3;
	// clock source select encodings
	localparam logic [1:0] CLKSRC_CRYSTAL = 2'h0;
	localparam logic [1:0] CLKSRC_EXTERN  = 2'h2;
	localparam logic [1:0] CLKSRC_RC      = 2'h3;
	typedef enum logic [2:0] {
		SENSE_IDLE  = 3'b001,
		SENSE_LEVEL = 3'b010,
		SENSE_EDGE  = 3'b100
	} sense_type;
endpackage

// File: core/pin_sense.sv
// one detector lane: synchroniser, level and edge detection for one pin
`timescale 1ns/10ps
module pin_sense
	import pin_irq_pkg::*;
(
	// clock and reset
	input  wire logic CLK,
	input  wire logic RESET,
	input  wire logic CE,
	// pin and configuration
	input  wire logic PIN,
	input  wire logic EDGE_MODE,
	input  wire logic ACTIVE_HIGH,
	input  wire logic LEVEL_TWICE,
	// result
	output logic      DETECT
);
	logic      sync1_reg;
	logic      sync2_reg;
	logic      prev_reg;
	logic      prev_valid_reg;
	sense_type state;
	logic      level_now;
	logic      level_prev;
	logic      edge_hit;
	logic      level_hit;

	// first stage feeds only the second stage
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sync1_reg      <= 1'b1;
			sync2_reg      <= 1'b1;
			prev_reg       <= 1'b1;
			prev_valid_reg <= 1'b0;
		end
		else if (CE)
		begin
			sync1_reg      <= PIN;
			sync2_reg      <= sync1_reg;
			prev_reg       <= sync2_reg;
			prev_valid_reg <= 1'b1;
		end
	end

	assign level_now  = ACTIVE_HIGH ? sync2_reg : ~sync2_reg;
	assign level_prev = ACTIVE_HIGH ? prev_reg : ~prev_reg;
	// previous sample inactive, current active: edge in the chosen direction
	assign edge_hit   = prev_valid_reg & ~level_prev & level_now;
	// port lanes need two equal samples, ext lanes need one
	assign level_hit  = level_now & (~LEVEL_TWICE | (prev_valid_reg & level_prev));
	assign state      = EDGE_MODE ? SENSE_EDGE : SENSE_LEVEL;

	always_comb
	begin
		case (state)
			SENSE_LEVEL: DETECT = level_hit;
			SENSE_EDGE:  DETECT = edge_hit;
			default:     DETECT = 1'b0;
		endcase
	end
endmodule

// File: verif/pin_source_model.sv
// partner model: outside sources driving the interrupt and port pins
`timescale 1ns/10ps
module pin_source_model
(
	// clock
	input  wire logic clk,
	// driven pins
	output logic       osc_a,
	output logic       osc_b,
	output logic [7:0] port
);
	initial
	begin
		osc_a = 1'b1;
		osc_b = 1'b1;
		port = 8'h01;
	end
	// levels held n edges; callers keep n >= 2 on the oscillator pins
	task automatic drive(input logic a, input logic b, input logic [7:0] p, input int n);
		osc_a <= a;
		osc_b <= b;
		port <= p;
		repeat (n) @(posedge clk);
	endtask
endmodule

// File: verif/pin_interrupt_detector_asserts.sv
// checker: port-level assertions for the pin interrupt detector
`timescale 1ns/10ps
module pin_interrupt_detector_asserts
	import pin_irq_pkg::*;
(
	// clock and reset
	input wire logic       CLK,
	input wire logic       RESET,
	// strap, pins, vectoring
	input wire logic [1:0] CLK_SOURCE,
	input wire logic       OSC_PIN_A,
	input wire logic       OSC_PIN_B,
	input wire logic [1:0] EXT_SERVICE_ENTER,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	// requests
	input wire logic [1:0] EXT_IRQ_REQUEST,
	input wire logic       PORT_IRQ_REQUEST,
	input wire logic       IRQ
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RESET);
	sequence a_low_held_s;
		CLK_SOURCE == CLKSRC_RC && $fell(OSC_PIN_A)
		##1 (!OSC_PIN_A && EXT_SERVICE_ENTER == 2'b00 && !WR) [*2];
	endsequence
	rc_zero_req_a: assert property (a_low_held_s |-> ##[0:1] EXT_IRQ_REQUEST[0])
		else $error("ext request 0 missing after held low input");
	crystal_none_a: assert property (CLK_SOURCE == CLKSRC_CRYSTAL |-> EXT_IRQ_REQUEST == 2'b00)
		else $error("ext request while crystal selected");
	extern_b_only_a: assert property (CLK_SOURCE == CLKSRC_EXTERN |-> !EXT_IRQ_REQUEST[0])
		else $error("ext request 0 with external clock");
	ext_rise_cause_a: assert property ($rose(EXT_IRQ_REQUEST[0]) && !$past(WR) |-> !$past(OSC_PIN_A, 2))
		else $error("ext request 0 rose without low input");
	service_clear_a: assert property (EXT_SERVICE_ENTER[1] && !WR && $past(OSC_PIN_B)
		&& $past(OSC_PIN_B, 2) |=> !EXT_IRQ_REQUEST[1])
		else $error("ext request 1 kept after service entry");
	port_sticky_a: assert property (PORT_IRQ_REQUEST && !(WR && ADDR == ADDR_FLAGS) |=> PORT_IRQ_REQUEST)
		else $error("port request dropped without flag write");
	irq_fall_a: assert property ($fell(IRQ) |-> $past(RD && ADDR == ADDR_IRQ_STAT
		|| WR && ADDR == ADDR_IRQ_MASK))
		else $error("interrupt fell without status read or mask write");
	rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data outside read answer cycle");
endmodule

// File: verif/pin_interrupt_detector_tb_top.sv
// testbench: register and pin scenarios for the pin interrupt detector
`timescale 1ns/10ps
module pin_interrupt_detector_tb_top
	import pin_irq_pkg::*;
	;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [1:0] src = CLKSRC_RC;
	logic [1:0] svc = 2'b00;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       ce = 1'b1;
	logic       osc_a;
	logic       osc_b;
	logic [7:0] port;
	logic [7:0] rdata;
	logic [1:0] ext;
	logic       preq;
	logic       irq;
	int         n_mismatch = 0;
	int         checks = 0;
	always #12.5 clk = ~clk;
	pin_source_model u_pin_source_model (.clk(clk), .osc_a(osc_a), .osc_b(osc_b), .port(port));
	pin_interrupt_detector u_pin_interrupt_detector (.CLK(clk), .RESET(reset), .CE(ce),
		.CLK_SOURCE(src), .OSC_PIN_A(osc_a), .OSC_PIN_B(osc_b), .PORT_ONE_PIN(port),
		.EXT_SERVICE_ENTER(svc), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.EXT_IRQ_REQUEST(ext), .PORT_IRQ_REQUEST(preq), .IRQ(irq));
	task automatic summarize();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// step off the edge so a following call never re-drives wr in this time step
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	// strap only changes under reset, as it is captured at release
	task automatic rst(input logic [1:0] s);
		reset <= 1'b1;
		src <= s;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
	endtask
	initial
	begin
		rst(CLKSRC_RC);
		for (int a = 8'h9b; a < 8'ha2; a++) rd_reg(8'(a), 8'h00);
		rd_reg(8'h50, 8'h00);
		wr_reg(ADDR_MODE, 8'h09);
		wr_reg(ADDR_POLARITY, 8'h0a);
		// enable last: a pin enabled while still configured may latch a stale level
		wr_reg(ADDR_ENABLE, 8'h0b);
		ce <= 1'b0;
		wr_reg(ADDR_POLARITY, 8'hff);
		ce <= 1'b1;
		rd_reg(ADDR_MODE, 8'h09);
		rd_reg(ADDR_POLARITY, 8'h0a);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h00, 4);
		rd_reg(ADDR_FLAGS, 8'h01);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h02, 1);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h00, 4);
		rd_reg(ADDR_FLAGS, 8'h01);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h06, 2);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h00, 4);
		rd_reg(ADDR_FLAGS, 8'h03);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h08, 4);
		rd_reg(ADDR_FLAGS, 8'h0b);
		chk({7'h00, preq}, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr_reg(ADDR_IRQ_MASK, 8'h04);
		#1 chk({7'h00, irq}, 8'h01);
		rd_reg(ADDR_IRQ_STAT, 8'h04);
		chk({7'h00, irq}, 8'h00);
		wr_reg(ADDR_FLAGS, 8'h00);
		#1 chk({7'h00, preq}, 8'h00);
		u_pin_source_model.drive(1'b0, 1'b1, 8'h08, 3);
		#1 chk({6'h00, ext}, 8'h01);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h08, 3);
		#1 chk({6'h00, ext}, 8'h00);
		wr_reg(ADDR_EXT_CTRL, 8'h02);
		u_pin_source_model.drive(1'b1, 1'b0, 8'h08, 4);
		rd_reg(ADDR_EXT_CTRL, 8'h0a);
		u_pin_source_model.drive(1'b1, 1'b1, 8'h08, 3);
		svc <= 2'b10;
		@(posedge clk);
		svc <= 2'b00;
		rd_reg(ADDR_EXT_CTRL, 8'h02);
		for (int s = 0; s < 2; s++)
		begin
			u_pin_source_model.drive(1'b1, 1'b1, 8'h08, 2);
			rst(s ? CLKSRC_CRYSTAL : CLKSRC_EXTERN);
			u_pin_source_model.drive(1'b0, 1'b0, 8'h08, 4);
			#1 chk({6'h00, ext}, s ? 8'h00 : 8'h02);
		end
		summarize();
	end
	// hang guard
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule
bind pin_interrupt_detector pin_interrupt_detector_asserts u_pin_interrupt_detector_asserts (
	.CLK(CLK), .RESET(RESET), .CLK_SOURCE(CLK_SOURCE), .OSC_PIN_A(OSC_PIN_A),
	.OSC_PIN_B(OSC_PIN_B), .EXT_SERVICE_ENTER(EXT_SERVICE_ENTER), .ADDR(ADDR), .WR(WR),
	.RD(RD), .RDATA(RDATA), .EXT_IRQ_REQUEST(EXT_IRQ_REQUEST),
	.PORT_IRQ_REQUEST(PORT_IRQ_REQUEST), .IRQ(IRQ));
